//--- inc/wxt_defines.svh
// constants for the waveform extension: widths, register map, fields, reset values
`ifndef WXT_DEFINES_SVH
`define WXT_DEFINES_SVH

// ------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------
`define WXT_AW 8
`define WXT_DW 32
`define WXT_CH 4
`define WXT_PINS 8
`define WXT_DT_W 8
`define WXT_EV_CH 8

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define WXT_OFF_CTRL 8'h00
`define WXT_OFF_FAULT 8'h04
`define WXT_OFF_STATUS 8'h08
`define WXT_OFF_DT_LS 8'h0C
`define WXT_OFF_DT_HS 8'h10
`define WXT_OFF_OVR 8'h14
`define WXT_OFF_PAT 8'h18
`define WXT_OFF_INV 8'h1C
`define WXT_OFF_ACT 8'h20

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define WXT_CTRL_FIELD 5:0
`define WXT_ST_FAULT 0
`define WXT_ST_DTP 1
`define WXT_ST_PATP 2
`define WXT_BYTE0 7:0
`define WXT_BYTE1 15:8
`define WXT_HALF0 15:0
`define WXT_LANE0 0
`define WXT_LANE1 1

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define WXT_RST_BYTE 8'h00
`define WXT_RST_CTRL 6'h00
`define WXT_RST_HALF 16'h0000
`define WXT_RST_WORD 32'h0000_0000
`define WXT_DT_ZERO 8'h00
`define WXT_DT_ONE 8'h01
`define WXT_RESP_OKAY 2'b00
`define WXT_RESP_SLVERR 2'b10

`endif

//--- inc/wxt_pkg.sv
// types shared by the waveform extension modules
`include "wxt_defines.svh"

package wxt_pkg;

    // one captured register write from the bus slave
    typedef struct packed {
        logic [`WXT_AW-1:0] addr;
        logic [`WXT_DW-1:0] data;
        logic [3:0] strb;
    } wxt_wr_t;

    // control word, laid out as it sits in the control register
    typedef struct packed {
        logic fan_a;
        logic pat_en;
        logic [`WXT_CH-1:0] dti_en;
    } wxt_ctrl_t;

    // high side and low side dead times of one unit
    typedef struct packed {
        logic [`WXT_DT_W-1:0] hs;
        logic [`WXT_DT_W-1:0] ls;
    } wxt_dt_t;

    // pattern: per-pin level and per-pin take-over select
    typedef struct packed {
        logic [`WXT_PINS-1:0] lvl;
        logic [`WXT_PINS-1:0] sel;
    } wxt_pat_t;

    // complementary output pair of one compare channel
    typedef struct packed {
        logic high;
        logic low;
    } wxt_pair_t;

endpackage : wxt_pkg

//--- rtl/wxt_axil_slave.sv
// axi4-lite slave front end: captures one write and one read at a time
`include "wxt_defines.svh"

module wxt_axil_slave (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`WXT_AW-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [`WXT_DW-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [`WXT_AW-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [`WXT_DW-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output wxt_pkg::wxt_wr_t wr_req,
    output logic wr_fire,
    input wire logic wr_err,
    output logic [`WXT_AW-1:0] rd_addr,
    input wire logic [`WXT_DW-1:0] rd_data,
    input wire logic rd_err
);

    logic aw_full_reg;
    logic w_full_reg;

    // write is performed once both halves are held and no answer is pending
    assign wr_fire = aw_full_reg && w_full_reg && !s_axil_bvalid;
    assign rd_addr = s_axil_araddr;

    // ------------------------------------------------------------
    // write address and data capture, in either order
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axil_awready <= 1'b0;
            s_axil_wready <= 1'b0;
            wr_req <= '0;
        end else if (clk_en) begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_full_reg <= 1'b1;
                s_axil_awready <= 1'b0;
                wr_req.addr <= s_axil_awaddr;
            end else if (s_axil_bvalid && s_axil_bready) begin
                aw_full_reg <= 1'b0;
                s_axil_awready <= 1'b1;
            end else if (!aw_full_reg) begin
                s_axil_awready <= 1'b1;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_full_reg <= 1'b1;
                s_axil_wready <= 1'b0;
                wr_req.data <= s_axil_wdata;
                wr_req.strb <= s_axil_wstrb;
            end else if (s_axil_bvalid && s_axil_bready) begin
                w_full_reg <= 1'b0;
                s_axil_wready <= 1'b1;
            end else if (!w_full_reg) begin
                s_axil_wready <= 1'b1;
            end
        end
    end

    // answer raised at the same edge as the register update
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= `WXT_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= wr_err ? `WXT_RESP_SLVERR : `WXT_RESP_OKAY;
            end else if (s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read: data sampled at the address handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axil_arready <= 1'b0;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= `WXT_RST_WORD;
            s_axil_rresp <= `WXT_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axil_arvalid && s_axil_arready) begin
                s_axil_arready <= 1'b0;
                s_axil_rvalid <= 1'b1;
                s_axil_rdata <= rd_data;
                s_axil_rresp <= rd_err ? `WXT_RESP_SLVERR : `WXT_RESP_OKAY;
            end else if (s_axil_rvalid && s_axil_rready) begin
                s_axil_rvalid <= 1'b0;
                s_axil_arready <= 1'b1;
            end else if (!s_axil_rvalid) begin
                s_axil_arready <= 1'b1;
            end
        end
    end

endmodule : wxt_axil_slave

//--- rtl/wxt_dead_time.sv
// one dead-time unit: splits a waveform into low side and high side pair
`include "wxt_defines.svh"

module wxt_dead_time #(
    parameter int DT_W = `WXT_DT_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wg,
    input wire wxt_pkg::wxt_dt_t dt,
    output wxt_pkg::wxt_pair_t pair
);

    logic wg_last_reg;
    logic [DT_W-1:0] cnt_reg;

    // ------------------------------------------------------------
    // edge tracking and dead-time count
    // ------------------------------------------------------------
    // both sides drop on every edge, so they never switch together
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wg_last_reg <= 1'b0;
            cnt_reg <= '0;
            pair <= '0;
        end else if (clk_en) begin
            if (wg != wg_last_reg) begin
                wg_last_reg <= wg;
                pair <= '0;
                cnt_reg <= wg ? dt.ls : dt.hs;
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - `WXT_DT_ONE;
            end else begin
                pair.low <= wg_last_reg;
                pair.high <= ~wg_last_reg;
            end
        end
    end

endmodule : wxt_dead_time

//--- rtl/wxt_top.sv
// waveform extension top: dead-time pairs, pattern generator, fault shutdown, registers
`include "wxt_defines.svh"

// Notes on behaviour
// - four dead-time units, one per compare channel of the timer
// - separate 8-bit high side and low side dead times, shared by all four units
// - each compare channel yields a complementary output pair
// - any enabled dead-time unit splits every waveform output into a pair
// - low side true, high side inverted, dead time between them
// - extension output replaces the port value only on override-selected pins, or on pattern-selected pins in pattern mode
// - per-pin invert setting inverts the final pin output
// - pattern unit drives a bit pattern, updated in step with the timer
// - in pattern mode channel A waveform may drive all selected pins
// - pattern mode bypasses the dead-time units
// - pattern is double buffered and loads only at a timer update
// - any selected event raises a fault that disables extension outputs
// - several event channels may trigger the fault at once
// - a single instance, tied to timer zero of port c
// - fault input listens to eight event channels
// - an event reaches the pins within two clock cycles
module wxt_top #(
    parameter int CH = `WXT_CH,
    parameter int PINS = `WXT_PINS,
    parameter int EV_CH = `WXT_EV_CH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`WXT_AW-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [`WXT_DW-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [`WXT_AW-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [`WXT_DW-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [CH-1:0] wg_in,
    input wire logic timer_update,
    input wire logic [PINS-1:0] port_value_in,
    input wire logic [EV_CH-1:0] event_in,
    output logic [PINS-1:0] pin_out,
    output logic fault_active
);

    wxt_pkg::wxt_wr_t wr_req;
    logic wr_fire;
    logic wr_err;
    logic [`WXT_AW-1:0] rd_addr;
    logic [`WXT_DW-1:0] rd_data;
    logic rd_err;

    wxt_pkg::wxt_ctrl_t ctrl_reg;
    logic [EV_CH-1:0] fault_mask_reg;
    wxt_pkg::wxt_dt_t dt_buf_reg;
    wxt_pkg::wxt_dt_t dt_act_reg;
    logic dt_pend_reg;
    logic [PINS-1:0] ovr_reg;
    logic [PINS-1:0] inv_reg;
    wxt_pkg::wxt_pat_t pat_buf_reg;
    wxt_pkg::wxt_pat_t pat_act_reg;
    logic pat_pend_reg;
    logic fault_reg;

    logic any_feature;
    logic fault_hit;
    logic fault_now;
    logic fault_clr;
    logic lane0;
    logic lane1;
    logic [CH-1:0] low_side_output;
    logic [CH-1:0] high_side_output;
    logic [PINS-1:0] ext_val;
    logic [PINS-1:0] ext_sel;
    logic [PINS-1:0] pin_next;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    wxt_axil_slave u_bus (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wr_req(wr_req),
        .wr_fire(wr_fire),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // true for every address that holds a register
    function automatic logic is_mapped(input logic [`WXT_AW-1:0] a);
        is_mapped = (a == `WXT_OFF_CTRL) || (a == `WXT_OFF_FAULT)
            || (a == `WXT_OFF_STATUS) || (a == `WXT_OFF_DT_LS)
            || (a == `WXT_OFF_DT_HS) || (a == `WXT_OFF_OVR)
            || (a == `WXT_OFF_PAT) || (a == `WXT_OFF_INV)
            || (a == `WXT_OFF_ACT);
    endfunction : is_mapped

    // write decode helpers; only low byte lanes carry register bits
    assign wr_err = !is_mapped(wr_req.addr);
    assign lane0 = wr_fire && wr_req.strb[`WXT_LANE0];
    assign lane1 = wr_fire && wr_req.strb[`WXT_LANE1];
    assign fault_clr = lane0 && (wr_req.addr == `WXT_OFF_STATUS)
        && wr_req.data[`WXT_ST_FAULT];

    // ------------------------------------------------------------
    // plain configuration registers
    // ------------------------------------------------------------
    // these take effect at once
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg <= `WXT_RST_CTRL;
            fault_mask_reg <= `WXT_RST_BYTE;
            ovr_reg <= `WXT_RST_BYTE;
            inv_reg <= `WXT_RST_BYTE;
        end else if (clk_en && lane0) begin
            unique case (wr_req.addr)
                `WXT_OFF_CTRL: ctrl_reg <= wr_req.data[`WXT_CTRL_FIELD];
                `WXT_OFF_FAULT: fault_mask_reg <= wr_req.data[`WXT_BYTE0];
                `WXT_OFF_OVR: ovr_reg <= wr_req.data[`WXT_BYTE0];
                `WXT_OFF_INV: inv_reg <= wr_req.data[`WXT_BYTE0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // double-buffered dead times
    // ------------------------------------------------------------
    // writes land in the buffer; the active copy moves at a timer update
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dt_buf_reg <= '0;
            dt_act_reg <= '0;
            dt_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (timer_update) begin
                dt_act_reg <= dt_buf_reg;
            end
            if (lane0 && wr_req.addr == `WXT_OFF_DT_LS) begin
                dt_buf_reg.ls <= wr_req.data[`WXT_BYTE0];
            end
            if (lane0 && wr_req.addr == `WXT_OFF_DT_HS) begin
                dt_buf_reg.hs <= wr_req.data[`WXT_BYTE0];
            end
            if (lane0 && (wr_req.addr == `WXT_OFF_DT_LS
                    || wr_req.addr == `WXT_OFF_DT_HS)) begin
                dt_pend_reg <= 1'b1;
            end else if (timer_update) begin
                dt_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // double-buffered pattern
    // ------------------------------------------------------------
    // select byte in lane 0, level byte in lane 1
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pat_buf_reg <= `WXT_RST_HALF;
            pat_act_reg <= `WXT_RST_HALF;
            pat_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (timer_update) begin
                pat_act_reg <= pat_buf_reg;
            end
            if (lane0 && wr_req.addr == `WXT_OFF_PAT) begin
                pat_buf_reg.sel <= wr_req.data[`WXT_BYTE0];
            end
            if (lane1 && wr_req.addr == `WXT_OFF_PAT) begin
                pat_buf_reg.lvl <= wr_req.data[`WXT_BYTE1];
            end
            if ((lane0 || lane1) && wr_req.addr == `WXT_OFF_PAT) begin
                pat_pend_reg <= 1'b1;
            end else if (timer_update) begin
                pat_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // fault protection
    // ------------------------------------------------------------
    // events come from logic on this clock, so they are not synchronised:
    // a synchroniser would break the two-cycle reaction budget
    assign fault_hit = |(event_in & fault_mask_reg);
    assign fault_now = fault_reg || fault_hit;

    // sticky until software writes one; a new event wins over the clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fault_reg <= 1'b0;
        end else if (clk_en) begin
            if (fault_hit) begin
                fault_reg <= 1'b1;
            end else if (fault_clr) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // dead-time units, one per compare channel
    // ------------------------------------------------------------
    // a disabled unit still splits its channel, with zero dead time
    generate
        for (genvar c = 0; c < CH; c++) begin : g_dti
            wxt_pkg::wxt_dt_t dt_use;
            wxt_pkg::wxt_pair_t pair;
            assign dt_use = ctrl_reg.dti_en[c] ? dt_act_reg : '0;
            wxt_dead_time #(
                .DT_W(`WXT_DT_W)
            ) u_dti (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .wg(wg_in[c]),
                .dt(dt_use),
                .pair(pair)
            );
            assign low_side_output[c] = pair.low;
            assign high_side_output[c] = pair.high;
        end
    endgenerate

    // ------------------------------------------------------------
    // per-pin output selection
    // ------------------------------------------------------------
    // pin 2c carries the low side of channel c, pin 2c+1 its high side
    assign any_feature = (|ctrl_reg.dti_en) || ctrl_reg.pat_en;

    generate
        for (genvar p = 0; p < PINS; p++) begin : g_pin
            always_comb begin
                if (ctrl_reg.pat_en) begin
                    ext_sel[p] = pat_act_reg.sel[p];
                    ext_val[p] = ctrl_reg.fan_a ? wg_in[0]
                        : pat_act_reg.lvl[p];
                end else begin
                    ext_sel[p] = ovr_reg[p];
                    if (!any_feature) begin
                        ext_val[p] = wg_in[p/2];
                    end else if (p % 2 == 0) begin
                        ext_val[p] = low_side_output[p/2];
                    end else begin
                        ext_val[p] = high_side_output[p/2];
                    end
                end
                if (!ext_sel[p]) begin
                    pin_next[p] = port_value_in[p] ^ inv_reg[p];
                end else if (fault_now) begin
                    pin_next[p] = inv_reg[p];
                end else begin
                    pin_next[p] = ext_val[p] ^ inv_reg[p];
                end
            end
        end
    endgenerate

    // the fault shows one edge after its event
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_out <= `WXT_RST_BYTE;
            fault_active <= 1'b0;
        end else if (clk_en) begin
            pin_out <= pin_next;
            fault_active <= fault_now;
        end
    end

    // ------------------------------------------------------------
    // register read-back
    // ------------------------------------------------------------
    // reads have no side effects; unused bits read zero
    always_comb begin
        rd_data = `WXT_RST_WORD;
        rd_err = 1'b0;
        unique case (rd_addr)
            `WXT_OFF_CTRL: rd_data[`WXT_CTRL_FIELD] = ctrl_reg;
            `WXT_OFF_FAULT: rd_data[`WXT_BYTE0] = fault_mask_reg;
            `WXT_OFF_STATUS: begin
                rd_data[`WXT_ST_FAULT] = fault_reg;
                rd_data[`WXT_ST_DTP] = dt_pend_reg;
                rd_data[`WXT_ST_PATP] = pat_pend_reg;
            end
            `WXT_OFF_DT_LS: rd_data[`WXT_BYTE0] = dt_buf_reg.ls;
            `WXT_OFF_DT_HS: rd_data[`WXT_BYTE0] = dt_buf_reg.hs;
            `WXT_OFF_OVR: rd_data[`WXT_BYTE0] = ovr_reg;
            `WXT_OFF_PAT: rd_data[`WXT_HALF0] = pat_buf_reg;
            `WXT_OFF_INV: rd_data[`WXT_BYTE0] = inv_reg;
            `WXT_OFF_ACT: rd_data[`WXT_HALF0] = dt_act_reg;
            default: rd_err = 1'b1;
        endcase
    end

    // one instance per chip, its wg_in wired to timer zero of port c

endmodule : wxt_top

//--- test/dead_time_waveform_extension_bench.sv
// bench for the waveform extension
`include "wxt_defines.svh"
module dead_time_waveform_extension_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LS = 2;
    localparam int HS = 5;
    logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, run = 1'b0, gap_on = 1'b0, w;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, timer_update, fault_active;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp, prev = 2'b00;
    logic [3:0] s_axil_wstrb = 4'hF, wg_in;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00, port_value_in = 8'h00;
    logic [7:0] event_in = 8'h00, pin_out, lvl;
    logic [7:0] evs[3] = '{8'h02, 8'h80, 8'h01};
    logic [31:0] s_axil_wdata = 32'h0000_0000, s_axil_rdata;
    logic [33:0] exp_q[$];
    int seed = 32'h0000_bf16, num_errors = 0, checks_done = 0, gap = 0;
    wxt_top wxt_top_i (.*);
    wxt_timer_model wxt_timer_model_i (.clk_sys, .run, .wg_in, .timer_update);
    always #2 clk_sys = ~clk_sys;
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // a wait that runs out ends the run at once, without counting an error
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys);
        {s_axil_awaddr, s_axil_wdata} <= {a, d};
        {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
            n++;
        end while (!s_axil_bvalid && n < 64);
        s_axil_bready <= 1'b0;
        if (n >= 64) close_out;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n = 0;
        @(posedge clk_sys);
        exp_q.push_back(e);
        s_axil_araddr <= a;
        {s_axil_arvalid, s_axil_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
            n++;
        end while (!s_axil_rvalid && n < 64);
        s_axil_rready <= 1'b0;
        if (n >= 64) close_out;
    endtask : rd
    // read answers meet the oldest noted expectation
    always @(posedge clk_sys) begin
        if (s_axil_rvalid && s_axil_rready)
            chk({s_axil_rresp, s_axil_rdata}, exp_q.pop_front());
    end
    // both-off gap lasts dead time plus one
    always @(negedge clk_sys) begin
        if (gap_on && prev == 2'b00 && pin_out[1:0] != 2'b00)
            chk(34'(gap), 34'(pin_out[0] ? LS + 1 : HS + 1));
        gap = (pin_out[1:0] == 2'b00) ? gap + 1 : 0;
        prev = pin_out[1:0];
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        port_value_in <= 8'($random(seed));
        lvl = 8'($random(seed));
        wr(`WXT_OFF_DT_LS, 32'(LS));
        wr(`WXT_OFF_DT_HS, 32'(HS));
        rd(`WXT_OFF_ACT, 34'h0);
        run <= 1'b1;
        repeat (20) @(posedge clk_sys);
        run <= 1'b0;
        rd(`WXT_OFF_ACT, 34'(HS * 256 + LS));
        wr(`WXT_OFF_OVR, 32'h0000_0003);
        wr(`WXT_OFF_CTRL, 32'h0000_000F);
        repeat (10) @(posedge clk_sys);
        {gap_on, run} <= 2'h3;
        repeat (64) @(posedge clk_sys);
        {gap_on, run} <= 2'h0;
        @(negedge clk_sys) chk(34'(pin_out[7:2]), 34'(port_value_in[7:2]));
        wr(`WXT_OFF_PAT, {16'h0000, lvl, 8'hF0});
        wr(`WXT_OFF_CTRL, 32'h0000_0010);
        @(negedge clk_sys) chk(34'(pin_out), 34'(port_value_in));
        @(posedge clk_sys) run <= 1'b1;
        repeat (20) @(posedge clk_sys);
        run <= 1'b0;
        @(negedge clk_sys) chk(34'(pin_out), 34'({lvl[7:4], port_value_in[3:0]}));
        wr(`WXT_OFF_CTRL, 32'h0000_0030);
        @(posedge clk_sys) run <= 1'b1;
        repeat (20) begin
            w = wg_in[0];
            @(negedge clk_sys) chk(34'(pin_out[7:4]), 34'({4{w}}));
        end
        @(posedge clk_sys) run <= 1'b0;
        wr(`WXT_OFF_CTRL, 32'h0000_0010);
        wr(`WXT_OFF_INV, 32'h0000_005A);
        wr(`WXT_OFF_FAULT, 32'h0000_0081);
        @(negedge clk_sys) chk(34'(pin_out), 34'({lvl[7:4], port_value_in[3:0]} ^ 8'h5A));
        foreach (evs[i]) begin
            @(posedge clk_sys) event_in <= evs[i];
            @(posedge clk_sys) event_in <= 8'h00;
            @(negedge clk_sys) chk(34'(fault_active), 34'(|(evs[i] & 8'h81)));
            if (|(evs[i] & 8'h81)) begin
                chk(34'(pin_out), 34'({4'h0, port_value_in[3:0]} ^ 8'h5A));
                rd(`WXT_OFF_STATUS, 34'h1);
                wr(`WXT_OFF_STATUS, 32'h0000_0001);
                @(negedge clk_sys) chk(34'(fault_active), 34'h0);
            end
        end
        rd(8'h40, {2'b10, 32'h0000_0000});
        @(posedge clk_sys) clk_en <= 1'b0;
        port_value_in <= ~port_value_in;
        repeat (3) @(posedge clk_sys);
        clk_en <= 1'b1;
        close_out;
    end
endmodule : dead_time_waveform_extension_bench

//--- test/wxt_assertions.sv
// port checker for the waveform extension
`include "wxt_defines.svh"
module wxt_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [`WXT_DW-1:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [`WXT_PINS-1:0] pin_out,
    input wire logic fault_active
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // write taken, then two enabled edges
    sequence wr_take_s;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready && clk_en
        ##1 clk_en ##1 clk_en;
    endsequence
    wr_answer_a: assert property (wr_take_s |-> s_axil_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axil_arvalid && s_axil_arready && clk_en |=> s_axil_rvalid)
        else $error("read answer late");
    b_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
        else $error("write answer dropped");
    r_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> $stable(s_axil_rdata))
        else $error("read data moved");
    wr_busy_a: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
        else $error("write ready too early");
    rd_busy_a: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("read ready too early");
    fault_clear_a: assert property ($fell(fault_active) |-> $past(s_axil_bvalid))
        else $error("fault cleared without write");
    freeze_a: assert property (!clk_en |=> $stable(pin_out) && $stable(fault_active))
        else $error("state moved while frozen");
endmodule : wxt_checker
bind wxt_top wxt_checker wxt_checker_i (.*);

//--- test/wxt_timer_model.sv
// timer model: four compare waveforms and the update pulse
module wxt_timer_model (
    input wire logic clk_sys,
    input wire logic run,
    output logic [3:0] wg_in,
    output logic timer_update
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg;
    // period of 16 at half duty; waveforms idle low while stopped
    always_ff @(posedge clk_sys) begin
        cnt_reg <= run ? cnt_reg + 4'h1 : 4'h0;
    end
    assign wg_in = {4{run & ~cnt_reg[3]}};
    assign timer_update = run & (cnt_reg == 4'hF);
endmodule : wxt_timer_model
